// [core/dpc_port_ctrl.sv]
// Host-side controller for one port of an asynchronous dual-port RAM
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_port_ctrl #(
    parameter int AW = 13,
    parameter int DW = 16
) (
    input  wire logic               mclk,        // System clock
    input  wire logic               reset,       // Synchronous reset
    input  wire logic               op_req,      // Start an access
    input  wire logic               op_we,       // 1 write, 0 read
    input  wire logic               op_token,    // Access token latch instead of RAM
    input  wire logic [AW-1:0]      op_addr,     // Access address
    input  wire logic [DW-1:0]      op_wdata,    // Write data
    input  wire dpc_pkg::dpc_lanes_t op_lanes,   // Lanes, bit1 high byte, bit0 low byte
    output var  logic               op_ready,    // Idle, request taken
    output var  logic               op_done,     // Access finished
    output var  logic [DW-1:0]      op_rdata,    // Read data
    output var  logic               busy_seen,   // Filtered busy level, high when busy
    output var  logic               msg_flag,    // Filtered message flag, high when set
    output var  logic               cs_n,        // Chip select
    output var  logic               rw_n,        // Direction strobe, high read
    output var  logic               oe_n,        // Output enable
    output var  logic               token_select_n,     // Token latch select
    output var  logic               high_lane_enable_n, // Upper byte enable
    output var  logic               low_lane_enable_n,  // Lower byte enable
    output var  logic [AW-1:0]      addr,        // Address pins
    output var  logic [DW-1:0]      data_o,      // Data pins out
    output var  logic               data_oe,     // Data pins driven
    input  wire logic [DW-1:0]      data_i,      // Data pins in
    input  wire logic               busy_n,      // Busy pin from device
    input  wire logic               int_n        // Message flag pin from device
);
    import dpc_pkg::*;

    localparam logic [3:0] RC_CYC  = 4'(`DPC_RC_CYC + `DPC_SYNC_CYC);
    localparam logic [3:0] WP_CYC  = 4'((`DPC_PWE_CYC > `DPC_SD_CYC) ? `DPC_PWE_CYC : `DPC_SD_CYC);
    localparam logic [3:0] REC_CYC = 4'((`DPC_HZ_CYC > `DPC_SWRD_CYC) ? `DPC_HZ_CYC : `DPC_SWRD_CYC);
    localparam logic [3:0] WH_CYC  = 4'(`DPC_WH_CYC);

    typedef struct packed {
        dpc_state_t     st;
        logic [3:0]     cnt;
        logic [3:0]     bhc;
        logic           ready;
        logic           done;
        logic [DW-1:0]  rdata;
        logic           cs_n;
        logic           rw_n;
        logic           oe_n;
        logic           tok_n;
        logic           hle_n;
        logic           lle_n;
        logic [AW-1:0]  addr;
        logic [DW-1:0]  dout;
        logic           doe;
        logic [2:0]     bsy_s;
        logic [2:0]     int_s;
        logic           busy_f;
        logic           int_f;
        logic [DW-1:0]  d1;
        logic [DW-1:0]  d2;
        logic [DW-1:0]  d3;
        logic           we;
        logic           tok;
        logic [1:0]     lanes;
    } dpc_ctl_t;

    localparam dpc_ctl_t CTL_RST = '{st: dpc_st_idle, ready: 1'b1, cs_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
                                     tok_n: 1'b1, hle_n: 1'b1, lle_n: 1'b1, bsy_s: 3'h7, int_s: 3'h7,
                                     busy_f: 1'b1, int_f: 1'b1, default: '0};

    dpc_ctl_t s_reg;
    dpc_ctl_t s_next;
    logic     busy_ok;

    assign busy_ok = s_reg.busy_f && (s_reg.bhc >= WH_CYC);

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        // Three-stage pin synchronisers, level moves once stages two and three agree
        s_next.bsy_s = {s_reg.bsy_s[1:0], busy_n};
        s_next.int_s = {s_reg.int_s[1:0], int_n};
        s_next.d1 = data_i;
        s_next.d2 = s_reg.d1;
        s_next.d3 = s_reg.d2;
        if (s_reg.bsy_s[1] == s_reg.bsy_s[2]) begin
            s_next.busy_f = s_reg.bsy_s[2];
        end
        if (s_reg.int_s[1] == s_reg.int_s[2]) begin
            s_next.int_f = s_reg.int_s[2];
        end
        if (!s_reg.busy_f) begin
            s_next.bhc = '0;
        end else if (s_reg.bhc != 4'hf) begin
            s_next.bhc = s_reg.bhc + 4'h1;
        end
        unique case (s_reg.st)
            dpc_st_idle: begin
                if (op_req) begin
                    s_next.ready = 1'b0;
                    s_next.we    = op_we;
                    s_next.tok   = op_token;
                    s_next.lanes = (op_lanes == 2'h0) ? 2'h3 : op_lanes;
                    s_next.addr  = op_addr;
                    s_next.dout  = op_wdata;
                    s_next.cnt   = '0;
                    s_next.st    = dpc_st_setup;
                end
            end
            dpc_st_setup: begin
                if (!s_reg.we) begin
                    // Select, lanes and output enable fall together after the address settled
                    s_next.cs_n  = s_reg.tok;
                    s_next.tok_n = !s_reg.tok;
                    s_next.hle_n = !s_reg.lanes[1];
                    s_next.lle_n = !s_reg.lanes[0];
                    s_next.oe_n  = 1'b0;
                    s_next.cnt   = '0;
                    s_next.st    = dpc_st_rwait;
                end else if (busy_ok) begin
                    // Slave device ignores writes while busy, so wait for busy to clear
                    s_next.rw_n  = 1'b0;
                    s_next.doe   = 1'b1;
                    s_next.hle_n = !s_reg.lanes[1];
                    s_next.lle_n = !s_reg.lanes[0];
                    s_next.st    = dpc_st_wdir;
                end
            end
            dpc_st_rwait: begin
                s_next.cnt = (s_reg.cnt == 4'hf) ? s_reg.cnt : s_reg.cnt + 4'h1;
                if ((s_reg.cnt >= RC_CYC) && (s_reg.d2 == s_reg.d3)) begin
                    s_next.rdata = s_reg.d3;
                    // Deselect after every read so token reads are never continuous
                    s_next.cs_n  = 1'b1;
                    s_next.tok_n = 1'b1;
                    s_next.oe_n  = 1'b1;
                    s_next.hle_n = 1'b1;
                    s_next.lle_n = 1'b1;
                    s_next.cnt   = '0;
                    s_next.st    = dpc_st_recov;
                end
            end
            dpc_st_wdir: begin
                // Select falls after the direction strobe so the device never drives
                s_next.cs_n  = s_reg.tok;
                s_next.tok_n = !s_reg.tok;
                s_next.cnt   = '0;
                s_next.st    = dpc_st_wsel;
            end
            dpc_st_wsel: begin
                s_next.cnt = s_reg.cnt + 4'h1;
                if (s_reg.cnt + 4'h1 >= WP_CYC) begin
                    s_next.rw_n = 1'b1;
                    s_next.st   = dpc_st_wend;
                end
            end
            dpc_st_wend: begin
                s_next.cs_n  = 1'b1;
                s_next.tok_n = 1'b1;
                s_next.hle_n = 1'b1;
                s_next.lle_n = 1'b1;
                s_next.doe   = 1'b0;
                s_next.cnt   = '0;
                s_next.st    = dpc_st_recov;
            end
            dpc_st_recov: begin
                // Covers device output turn-off and token write-to-read time
                s_next.cnt = s_reg.cnt + 4'h1;
                if (s_reg.cnt + 4'h1 >= REC_CYC) begin
                    s_next.done  = 1'b1;
                    s_next.ready = 1'b1;
                    s_next.st    = dpc_st_idle;
                end
            end
            default: begin
                // Unused state code falls back to idle
                s_next.st = dpc_st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_reg <= CTL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    always_comb begin
        op_ready           = s_reg.ready;
        op_done            = s_reg.done;
        op_rdata           = s_reg.rdata;
        busy_seen          = !s_reg.busy_f;
        msg_flag           = !s_reg.int_f;
        cs_n               = s_reg.cs_n;
        rw_n               = s_reg.rw_n;
        oe_n               = s_reg.oe_n;
        token_select_n     = s_reg.tok_n;
        high_lane_enable_n = s_reg.hle_n;
        low_lane_enable_n  = s_reg.lle_n;
        addr               = s_reg.addr;
        data_o             = s_reg.dout;
        data_oe            = s_reg.doe;
    end

    a_read_dir_high: assert property (@(posedge mclk) disable iff (reset)
        !s_reg.oe_n |-> s_reg.rw_n) else $error("direction strobe low during read");
    a_addr_hold_write: assert property (@(posedge mclk) disable iff (reset)
        !s_reg.rw_n |-> $stable(s_reg.addr)) else $error("address moved while direction strobe low");
    a_addr_before_sel: assert property (@(posedge mclk) disable iff (reset)
        ($fell(s_reg.cs_n) || $fell(s_reg.tok_n)) |-> $stable(s_reg.addr)) else $error("address changed at select");
    a_no_bus_fight: assert property (@(posedge mclk) disable iff (reset)
        s_reg.doe |-> (s_reg.oe_n && $past(s_reg.oe_n, 2))) else $error("driving data while device may drive");
    a_token_cs_high: assert property (@(posedge mclk) disable iff (reset)
        !s_reg.tok_n |-> (s_reg.cs_n && (s_reg.hle_n == 1'b0 || s_reg.lle_n == 1'b0))) else $error("token access bad select");
    a_ram_select: assert property (@(posedge mclk) disable iff (reset)
        !s_reg.cs_n |-> (s_reg.tok_n && !(s_reg.hle_n && s_reg.lle_n))) else $error("ram access bad enables");
    a_write_end: assert property (@(posedge mclk) disable iff (reset)
        $rose(s_reg.rw_n) |-> (!$past(s_reg.cs_n) || !$past(s_reg.tok_n)) ##1 (s_reg.cs_n && s_reg.tok_n && !s_reg.doe))
        else $error("write did not end on direction strobe");
    a_sel_after_dir: assert property (@(posedge mclk) disable iff (reset)
        (($fell(s_reg.cs_n) || $fell(s_reg.tok_n)) && !s_reg.rw_n) |-> !$past(s_reg.rw_n) && s_reg.doe)
        else $error("select fell before direction strobe");
    a_write_pulse: assert property (@(posedge mclk) disable iff (reset)
        ($fell(s_reg.cs_n) || $fell(s_reg.tok_n)) && !s_reg.rw_n |-> !s_reg.rw_n [*3]) else $error("write pulse short");
    a_busy_holdoff: assert property (@(posedge mclk) disable iff (reset)
        $fell(s_reg.rw_n) |-> $past(busy_ok)) else $error("write started while busy");
    a_read_deselect: assert property (@(posedge mclk) disable iff (reset)
        s_reg.done |-> (s_reg.cs_n && s_reg.tok_n && s_reg.oe_n && s_reg.rw_n)) else $error("still selected at done");
endmodule
`default_nettype wire

// [core/dpc_regs.svh]
// Timing counts and operation summary for the dual-port RAM port controller
// Operation
// - Direction strobe stays high for the whole of every read cycle.
// - Continuous-select reads follow address; semaphore reads never use that form.
// - Address is valid no later than the falling edge of the select.
// - Direction strobe is high whenever the port address changes; a reset during a write zeroes the address as the strobe rises.
// - Never drive the data pins while the device drives them.
// - Chip select stays high through a semaphore write and following read.
// - RAM access: select and lane low, token high; token access: select high.
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

`define DPC_CLK_NS        5
`define DPC_CYC_UP(t)     ((((t)) + `DPC_CLK_NS - 1) / `DPC_CLK_NS)
`define DPC_T_RC_NS       15
`define DPC_T_PWE_NS      12
`define DPC_T_SD_NS       10
`define DPC_T_HZ_NS       10
`define DPC_T_SWRD_NS     5
`define DPC_T_WH_NS       13
`define DPC_RC_CYC        `DPC_CYC_UP(`DPC_T_RC_NS)
`define DPC_PWE_CYC       `DPC_CYC_UP(`DPC_T_PWE_NS)
`define DPC_SD_CYC        `DPC_CYC_UP(`DPC_T_SD_NS)
`define DPC_HZ_CYC        `DPC_CYC_UP(`DPC_T_HZ_NS)
`define DPC_SWRD_CYC      `DPC_CYC_UP(`DPC_T_SWRD_NS)
`define DPC_WH_CYC        `DPC_CYC_UP(`DPC_T_WH_NS)
`define DPC_SYNC_CYC      2
`define DPC_TOKEN_BIT     0

`endif

// [core/dpc_pkg.sv]
// Types shared by the dual-port RAM port controller
package dpc_pkg;
    typedef logic [1:0] dpc_lanes_t;
    typedef enum logic [2:0] {
        dpc_st_idle,
        dpc_st_setup,
        dpc_st_rwait,
        dpc_st_wdir,
        dpc_st_wsel,
        dpc_st_wend,
        dpc_st_recov
    } dpc_state_t;
endpackage

// [verif/dpc_dev_model.sv]
// Behavioural model of one device port: RAM array, token latches, busy and message flag
`timescale 1ns/1ps
`default_nettype none
module dpc_dev_model #(
    parameter int          AW   = 13,
    parameter logic [12:0] MBOX = 13'h1fff
) (
    input  wire logic          mclk,               // Paces the idle bus pattern only
    input  wire logic          cs_n,               // Chip select
    input  wire logic          rw_n,               // Direction strobe
    input  wire logic          oe_n,               // Output enable
    input  wire logic          token_select_n,     // Token latch select
    input  wire logic          high_lane_enable_n, // Upper byte enable
    input  wire logic          low_lane_enable_n,  // Lower byte enable
    input  wire logic [AW-1:0] addr,               // Address pins
    input  wire logic [15:0]   data_o,             // Host data
    input  wire logic          data_oe,            // Host drives data
    input  wire logic          busy_hold,          // Other port holds this one off
    input  wire logic          peer_msg,           // Other port writes our mailbox
    input  wire logic [7:0]    peer_tok,           // Tokens held by the other port
    output var  logic [15:0]   data_i,             // Data pins to host
    output var  logic          busy_n,             // Busy pin
    output var  logic          int_n,              // Message flag pin
    output var  logic          clash               // Both sides drive the data pins
);
    logic [15:0] mem [2**AW];
    logic [7:0]  own  = 8'h00;
    logic        flag = 1'b0;
    logic        tgl  = 1'b0;
    wire         lane   = ~high_lane_enable_n | ~low_lane_enable_n;
    wire         ram    = ~cs_n & token_select_n & lane;
    wire         tok    = cs_n & ~token_select_n;
    wire         wr_ram = ram & ~rw_n;
    wire         wr_tok = tok & ~rw_n;
    wire         rd     = rw_n & ~oe_n & (ram | tok);
    wire [15:0]  d      = data_oe ? data_o : ~data_o;

    always @(posedge mclk) tgl <= ~tgl;
    // Commit happens when the overlap ends, whichever strobe rises first
    always @(negedge wr_ram) begin
        if (!high_lane_enable_n) mem[addr][15:8] = d[15:8];
        if (!low_lane_enable_n) mem[addr][7:0] = d[7:0];
    end
    always @(negedge wr_tok) begin
        // Only a clean zero claims; an unsettled bus at power-up releases
        if (d[0] === 1'b0) own[addr[2:0]] <= ~peer_tok[addr[2:0]];
        else own[addr[2:0]] <= 1'b0;
    end
    always @(posedge peer_msg or negedge cs_n) begin
        if (peer_msg) flag <= 1'b1;
        else if (rw_n && addr == MBOX) flag <= 1'b0;
    end
    // Released bus shows a moving pattern, never the last value
    always @* begin
        if (!rd) data_i = {8{tgl, ~tgl}};
        else if (tok) data_i = {15'h7fff, ~own[addr[2:0]]};
        else data_i = {high_lane_enable_n ? 8'h3c : mem[addr][15:8],
                       low_lane_enable_n ? 8'hc3 : mem[addr][7:0]};
    end
    // Other port arrived first and keeps priority while it holds busy
    assign busy_n = ~busy_hold;
    assign int_n  = ~flag;
    assign clash  = rd & data_oe;
endmodule
`default_nettype wire

// [verif/tb_dpc_port_ctrl.sv]
// Self-checking bench for the dual-port RAM port controller
`timescale 1ns/1ps
`default_nettype none
module tb_dpc_port_ctrl;
    import dpc_pkg::*;
    logic        mclk = 0, reset = 1, op_req = 0, op_we = 0, op_token = 0;
    logic [12:0] op_addr = '0, addr, pa = '0;
    logic [15:0] op_wdata = '0, op_rdata, data_o, data_i;
    dpc_lanes_t  op_lanes = '0;
    logic        op_ready, op_done, busy_seen, msg_flag, cs_n, rw_n, oe_n, token_select_n;
    logic        high_lane_enable_n, low_lane_enable_n, data_oe, busy_n, int_n, clash;
    logic        busy_hold = 0, peer_msg = 0;
    logic [7:0]  peer_tok = '0;
    int          n_mismatch = 0, checks_done = 0, cyc = 0;

    dpc_port_ctrl i_dpc_port_ctrl (.mclk, .reset, .op_req, .op_we, .op_token, .op_addr, .op_wdata,
        .op_lanes, .op_ready, .op_done, .op_rdata, .busy_seen, .msg_flag, .cs_n, .rw_n, .oe_n,
        .token_select_n, .high_lane_enable_n, .low_lane_enable_n, .addr, .data_o, .data_oe,
        .data_i, .busy_n, .int_n);
    dpc_dev_model i_dpc_dev_model (.mclk, .cs_n, .rw_n, .oe_n, .token_select_n, .high_lane_enable_n,
        .low_lane_enable_n, .addr, .data_o, .data_oe, .busy_hold, .peer_msg, .peer_tok, .data_i,
        .busy_n, .int_n, .clash);

    always #2.5 mclk = ~mclk;

    task automatic results;
        if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chkw(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic start(input logic w, t, input logic [12:0] a, input logic [15:0] d, input dpc_lanes_t l);
        chk1("op_ready", 1'b1, op_ready);
        op_we = w;
        op_token = t;
        op_addr = a;
        op_wdata = d;
        op_lanes = l;
        op_req = 1;
        @(negedge mclk);
        op_req = 0;
    endtask
    task automatic await(input int lim, input logic e);
        int n;
        n = 0;
        while (op_done !== 1'b1 && n < lim) begin
            @(negedge mclk);
            n++;
        end
        chk1("op_done", e, op_done);
    endtask
    // Whole access; read data compared when w is low
    task automatic acc(input logic w, t, input logic [12:0] a, input logic [15:0] d, input dpc_lanes_t l);
        start(w, t, a, d, l);
        await(60, 1'b1);
        if (!w) chkw("op_rdata", d, op_rdata);
    endtask

    function automatic logic [15:0] idle_vec();
        return {5'h0, op_ready, cs_n, rw_n, oe_n, token_select_n,
                high_lane_enable_n, low_lane_enable_n, data_oe, op_done, busy_seen, msg_flag};
    endfunction
    task automatic t_idle;
        chkw("idle_pins", 16'h07f0, idle_vec());
        acc(0, 1, 13'h0, 16'hffff, 2'h1);
    endtask
    // Reset in the middle of a write must return every pin to idle
    task automatic t_reset;
        start(1, 0, 13'h7, 16'h7777, 2'h3);
        repeat (3) @(negedge mclk);
        reset = 1;
        repeat (3) @(negedge mclk);
        reset = 0;
        @(negedge mclk);
        chkw("reset_pins", 16'h07f0, idle_vec());
        acc(0, 1, 13'h1, 16'hffff, 2'h1);
        acc(1, 0, 13'h7, 16'h1357, 2'h3);
        acc(0, 0, 13'h7, 16'h1357, 2'h3);
    endtask
    task automatic t_lanes;
        acc(1, 0, 13'h5, 16'h1234, 2'h3);
        acc(1, 0, 13'h5, 16'habcd, 2'h2);
        acc(0, 0, 13'h5, 16'hab34, 2'h0);
        acc(1, 0, 13'h5, 16'h00ff, 2'h1);
        acc(0, 0, 13'h5, 16'habff, 2'h3);
    endtask
    task automatic t_token;
        peer_tok = 8'h10;
        acc(1, 1, 13'h2, 16'h0000, 2'h1);
        acc(0, 1, 13'h2, 16'hfffe, 2'h1);
        acc(0, 1, 13'h3, 16'hffff, 2'h1);
        acc(1, 1, 13'h4, 16'h0000, 2'h1);
        acc(0, 1, 13'h4, 16'hffff, 2'h1);
        acc(1, 1, 13'h2, 16'h0001, 2'h1);
        acc(0, 1, 13'h2, 16'hffff, 2'h1);
    endtask
    task automatic t_busy;
        busy_hold = 1;
        repeat (8) @(negedge mclk);
        chk1("busy_seen", 1'b1, busy_seen);
        start(1, 0, 13'h9, 16'h5a5a, 2'h3);
        await(30, 1'b0);
        busy_hold = 0;
        await(40, 1'b1);
        acc(0, 0, 13'h9, 16'h5a5a, 2'h3);
        chk1("busy_seen", 1'b0, busy_seen);
    endtask
    task automatic t_msg;
        peer_msg = 1;
        @(negedge mclk);
        peer_msg = 0;
        repeat (6) @(negedge mclk);
        chk1("msg_flag", 1'b1, msg_flag);
        acc(1, 0, 13'h1fff, 16'h0c0c, 2'h3);
        acc(0, 0, 13'h1fff, 16'h0c0c, 2'h3);
        repeat (6) @(negedge mclk);
        chk1("msg_flag", 1'b0, msg_flag);
    endtask

    // Pin-level watch of the host's side of the wire
    always @(negedge mclk) begin
        if (!reset && addr !== pa) chk1("rw_on_addr", 1'b1, rw_n);
        if (token_select_n === 1'b0) chk1("cs_in_token", 1'b1, cs_n);
        if (clash === 1'b1) chk1("bus_clash", 1'b0, clash);
        pa = addr;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        reset = 0;
        @(negedge mclk);
        t_idle();
        t_lanes();
        t_token();
        t_busy();
        t_msg();
        t_reset();
        results();
    end
endmodule
`default_nettype wire
